// ===== verilog/sipc_regs.svh
/*
  Constants for the target-side information phase controller: phase codes,
  retry limits and bus turnaround timing counts.
  Assumes a 10 MHz mclk; included by bare name.
*/
`ifndef SIPC_REGS_SVH
`define SIPC_REGS_SVH

// ==========================================
// Phase line codes {C/D, I/O, MSG}
`define SIPC_PH_COMMAND    3'h4
`define SIPC_PH_DT_IN      3'h3
`define SIPC_PH_DT_OUT     3'h1
`define SIPC_PH_ST_IN      3'h2
`define SIPC_PH_ST_OUT     3'h0
`define SIPC_PH_STATUS     3'h6
`define SIPC_PH_MSG_IN     3'h7
`define SIPC_PH_MSG_OUT    3'h5

// ==========================================
// Messages and status
`define SIPC_MSG_RESTORE   8'h03
`define SIPC_STS_CHECK     8'h02
`define SIPC_SK_ABORTED    4'hB
`define SIPC_ASC_PARITY    8'h47
`define SIPC_ASC_MSGERR    8'h43

// ==========================================
// Timing: clock period and delays in ns, counts derived
`define SIPC_CLK_NS        100
`define SIPC_RELEASE_NS    400
`define SIPC_SETTLE_NS     400
`define SIPC_DESKEW_NS     45
`define SIPC_TURN_IN_CYC   ((`SIPC_RELEASE_NS + `SIPC_SETTLE_NS + `SIPC_CLK_NS - 1) / `SIPC_CLK_NS)
`define SIPC_TURN_OUT_CYC  ((`SIPC_DESKEW_NS / `SIPC_CLK_NS) < 1 ? 1 : (`SIPC_DESKEW_NS / `SIPC_CLK_NS))
`define SIPC_RETRY_LIMIT   2

`endif

// ===== verilog/sipc_pkg.sv
/*
  Types shared by the phase controller files.
  Assumes sipc_regs.svh for numeric constants.
*/
package sipc_pkg;
    typedef enum logic [2:0] {
        SIPC_PHASE_COMMAND,
        SIPC_PHASE_DT_IN,
        SIPC_PHASE_DT_OUT,
        SIPC_PHASE_ST_IN,
        SIPC_PHASE_ST_OUT,
        SIPC_PHASE_STATUS,
        SIPC_PHASE_MSG_IN,
        SIPC_PHASE_MSG_OUT
    } sipc_phase_e;
endpackage

// ===== verilog/sipc_parity.sv
/*
  Odd parity generation and checking for both data lanes.
  Assumes the caller picks which lanes are checked in each phase.
*/
`timescale 1ns/1ps
`default_nettype none
module sipc_parity
(
    input  wire logic [15:0] data,
    input  wire logic        parLo,
    input  wire logic        parHi,
    output logic             genLo,
    output logic             genHi,
    output logic             errLo,
    output logic             errHi
);
    // ==========================================
    // Odd parity: bit set when the byte has an even count of ones
    assign genLo = ~^data[7:0];
    assign genHi = ~^data[15:8];
    assign errLo = genLo != parLo;
    assign errHi = genHi != parHi;
endmodule // sipc_parity
`default_nettype wire

// ===== verilog/sipc_turnaround.sv
/*
  Bus turnaround timer: counts cycles after an I/O change before the target
  may drive, or before the bus counts as released.
  Assumes single clock mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module sipc_turnaround #(
    parameter int CW = 4
)
(
    input  wire logic          mclk,
    input  wire logic          resetn,
    input  wire logic          start,
    input  wire logic [CW-1:0] count,
    output logic               busy
);
    logic [CW-1:0] cnt_q;

    // ==========================================
    // Load on start, count down to zero
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            cnt_q <= '0;
        else if (start)
            cnt_q <= count;
        else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
    end

    assign busy = start || (cnt_q != '0);
endmodule // sipc_turnaround
`default_nettype wire

// ===== verilog/sipc_target.sv
/*
  Target-side information transfer phase controller for a parallel bus.
  Assumes the user side supplies one byte request per transfer and that
  the initiator keeps its own rules; all inputs synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sipc_regs.svh"
module sipc_target
    import sipc_pkg::*;
#(
    parameter int RETRY_LIMIT = `SIPC_RETRY_LIMIT
)
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    // User side
    input  wire logic        phaseReq,
    input  wire sipc_phase_e phaseSel,
    input  wire logic        wideEn,
    input  wire logic [7:0]  txByte,
    input  wire logic        txLast,
    input  wire logic        xferReq,
    output logic             xferAck,
    output logic [7:0]       rxByte,
    output logic             rxValid,
    output logic             rxAct,
    output logic             rxParErr,
    output logic             msgRetryReq,
    output logic             cmdRetryReq,
    output logic             abortReq,
    output logic [3:0]       senseKey,
    output logic [7:0]       senseCode,
    output logic             busFreeReq,
    // Bus side
    output logic             cdOut,
    output logic             ioOut,
    output logic             msgOut,
    output logic             reqOut,
    input  wire logic        ackIn,
    input  wire logic        atnIn,
    input  wire logic [15:0] dbIn,
    input  wire logic        dbParLoIn,
    input  wire logic        dbParHiIn,
    output logic [15:0]      dbOut,
    output logic             dbParLoOut,
    output logic             dbParHiOut,
    output logic             dbOe
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_TURN,
        ST_REQ,
        ST_ACK,
        ST_RETRY
    } sipc_state_e;

    sipc_state_e   state_q, state_d;
    sipc_phase_e   phase_q;
    logic [2:0]    lines_q;
    logic [7:0]    loByte_q;
    logic          msgErr_q;
    logic [1:0]    retries_q;
    logic [3:0]    msgIdx_q;
    logic [3:0]    actedCnt_q;
    logic          reqOut_q;
    logic [15:0]   dbOut_q;
    logic          dbOe_q;
    logic          turnStart;
    logic          turnBusy;
    logic [3:0]    turnCount;
    logic          errLo;
    logic          errHi;
    logic          errHit;
    logic          inbound;
    logic          nonData;

    // ==========================================
    // Phase line code for each phase
    function automatic logic [2:0] phase_code(sipc_phase_e p);
        case (p)
            SIPC_PHASE_COMMAND: phase_code = `SIPC_PH_COMMAND;
            SIPC_PHASE_DT_IN:   phase_code = `SIPC_PH_DT_IN;
            SIPC_PHASE_DT_OUT:  phase_code = `SIPC_PH_DT_OUT;
            SIPC_PHASE_ST_IN:   phase_code = `SIPC_PH_ST_IN;
            SIPC_PHASE_ST_OUT:  phase_code = `SIPC_PH_ST_OUT;
            SIPC_PHASE_STATUS:  phase_code = `SIPC_PH_STATUS;
            SIPC_PHASE_MSG_IN:  phase_code = `SIPC_PH_MSG_IN;
            default:            phase_code = `SIPC_PH_MSG_OUT;
        endcase
    endfunction

    // ==========================================
    // Decode of direction and parity lane use
    assign inbound = lines_q[1];
    assign nonData = lines_q[2];
    assign errHit  = errLo || (!nonData && wideEn && errHi);
    assign cdOut   = lines_q[2];
    assign ioOut   = lines_q[1];
    assign msgOut  = lines_q[0];
    assign reqOut  = reqOut_q;
    assign dbOut   = dbOut_q;
    assign dbOe    = dbOe_q;
    assign turnCount = (phase_code(phaseSel) & 3'h2) != 3'h0
                     ? 4'(`SIPC_TURN_IN_CYC) : 4'(`SIPC_TURN_OUT_CYC);
    assign turnStart = (state_q == ST_IDLE) && phaseReq;

    sipc_parity u_par
    (
        .data  (dbIn),
        .parLo (dbParLoIn),
        .parHi (dbParHiIn),
        .genLo (),
        .genHi (),
        .errLo (errLo),
        .errHi (errHi)
    );

    sipc_turnaround u_turn
    (
        .mclk   (mclk),
        .resetn (resetn),
        .start  (turnStart),
        .count  (turnCount),
        .busy   (turnBusy)
    );

    // ==========================================
    // Parity driven for whatever sits on each lane
    assign dbParLoOut = ~^dbOut_q[7:0];
    assign dbParHiOut = ~^dbOut_q[15:8];

    // ==========================================
    // Handshake sequencer
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:  if (phaseReq) state_d = ST_TURN;
            ST_TURN:  if (!turnBusy) state_d = ST_REQ;
            ST_REQ:   if (ackIn) state_d = ST_ACK;
            ST_ACK:
                if (!ackIn)
                begin
                    if (phase_q == SIPC_PHASE_MSG_OUT && atnIn)
                        state_d = ST_REQ;
                    else if (phase_q == SIPC_PHASE_MSG_OUT && msgErr_q
                             && retries_q < 2'(RETRY_LIMIT))
                        state_d = ST_RETRY;
                    else if (phase_q != SIPC_PHASE_MSG_OUT && !txLast)
                        state_d = ST_REQ;
                    else
                        state_d = ST_IDLE;
                end
            ST_RETRY: state_d = ST_REQ;
            default:  state_d = ST_IDLE;
        endcase
    end

    // ==========================================
    // State, phase lines and request line
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q  <= ST_IDLE;
            phase_q  <= SIPC_PHASE_ST_OUT;
            lines_q  <= `SIPC_PH_ST_OUT;
            reqOut_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (turnStart)
            begin
                phase_q <= phaseSel;
                lines_q <= phase_code(phaseSel);
            end
            reqOut_q <= (state_d == ST_REQ) && (inbound ? xferReq || state_q == ST_REQ : 1'b1);
        end
    end

    // ==========================================
    // Data drive: a wide pair in one transfer, staged low byte on the low lane and current byte on the high lane, or zero there when txLast is set
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            dbOut_q  <= 16'h0000;
            dbOe_q   <= 1'b0;
        end
        else
        begin
            dbOe_q <= inbound && (state_d == ST_REQ || state_d == ST_ACK);
            if (inbound && state_q != ST_REQ && state_d == ST_REQ)
            begin
                if (wideEn && !nonData)
                    dbOut_q <= {txLast ? 8'h00 : txByte, loByte_q};
                else
                    dbOut_q <= {8'h00, txByte};
            end
        end
    end

    // ==========================================
    // User acknowledge of each sent byte and low byte staging
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            loByte_q <= 8'h00;
        else if (xferReq)
            loByte_q <= txByte;
    end
    assign xferAck = (state_q == ST_REQ) && ackIn;

    // ==========================================
    // Received bytes, parity errors and message replay tracking
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rxByte     <= 8'h00;
            rxValid    <= 1'b0;
            rxAct      <= 1'b0;
            rxParErr   <= 1'b0;
            msgErr_q   <= 1'b0;
            msgIdx_q   <= 4'h0;
            actedCnt_q <= 4'h0;
            retries_q  <= 2'h0;
        end
        else
        begin
            rxValid  <= 1'b0;
            rxAct    <= 1'b0;
            rxParErr <= 1'b0;
            if (turnStart)
            begin
                msgIdx_q <= 4'h0;
                msgErr_q <= 1'b0;
                if (phaseSel != SIPC_PHASE_MSG_OUT)
                    actedCnt_q <= 4'h0;
                // Command retries outlive the restore pointers message in between
                if (phaseSel != SIPC_PHASE_COMMAND && phaseSel != SIPC_PHASE_MSG_IN)
                    retries_q <= 2'h0;
            end
            else if (state_q == ST_RETRY)
            begin
                msgIdx_q  <= 4'h0;
                msgErr_q  <= 1'b0;
                retries_q <= retries_q + 2'h1;
            end
            else if (state_q == ST_ACK && state_d == ST_IDLE && msgErr_q)
            begin
                if (phase_q == SIPC_PHASE_COMMAND && retries_q < 2'(RETRY_LIMIT))
                    retries_q <= retries_q + 2'h1;
                else
                    retries_q <= 2'h0;
            end
            else if (!inbound && state_q == ST_REQ && ackIn)
            begin
                rxByte   <= dbIn[7:0];
                rxValid  <= 1'b1;
                rxParErr <= errHit;
                if (errHit)
                    msgErr_q <= 1'b1;
                msgIdx_q <= msgIdx_q + 4'h1;
                // Act only on clean bytes not acted on before
                if (!errHit && !msgErr_q && msgIdx_q >= actedCnt_q)
                begin
                    rxAct      <= 1'b1;
                    actedCnt_q <= msgIdx_q + 4'h1;
                end
            end
        end
    end

    // ==========================================
    // Exception reporting: message retry within message out, the rest after a phase ends
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cmdRetryReq <= 1'b0;
            msgRetryReq <= 1'b0;
            abortReq    <= 1'b0;
            busFreeReq  <= 1'b0;
            senseKey    <= 4'h0;
            senseCode   <= 8'h00;
        end
        else
        begin
            cmdRetryReq <= 1'b0;
            msgRetryReq <= state_q == ST_RETRY;
            abortReq    <= 1'b0;
            busFreeReq  <= 1'b0;
            if (state_q == ST_ACK && state_d == ST_IDLE && msgErr_q)
            begin
                if (phase_q == SIPC_PHASE_COMMAND && retries_q < 2'(RETRY_LIMIT))
                    cmdRetryReq <= 1'b1;
                else if (phase_q == SIPC_PHASE_MSG_OUT)
                begin
                    abortReq  <= 1'b1;
                    senseKey  <= `SIPC_SK_ABORTED;
                    senseCode <= `SIPC_ASC_MSGERR;
                end
                else
                begin
                    abortReq  <= 1'b1;
                    senseKey  <= `SIPC_SK_ABORTED;
                    senseCode <= `SIPC_ASC_PARITY;
                end
            end
            else if (state_q == ST_ACK && state_d == ST_IDLE && phase_q == SIPC_PHASE_MSG_OUT)
                busFreeReq <= 1'b0;
        end
    end
endmodule // sipc_target
`default_nettype wire

// ===== sim/sipc_target_sva.sv
/*
  Checker for the target phase controller, bound to its ports.
  Assumes one clock mclk and the async active-low reset resetn.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sipc_regs.svh"
module sipc_target_sva
(
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        reqOut,
    input wire logic        ackIn,
    input wire logic        atnIn,
    input wire logic        cdOut,
    input wire logic        ioOut,
    input wire logic        msgOut,
    input wire logic        dbOe,
    input wire logic        xferAck,
    input wire logic [15:0] dbOut,
    input wire logic        dbParLoOut,
    input wire logic        dbParHiOut,
    input wire logic        msgRetryReq,
    input wire logic        cmdRetryReq,
    input wire logic        abortReq,
    input wire logic [3:0]  senseKey,
    input wire logic [7:0]  senseCode
);
    // ==========================================
    // Handshake, phase lines and turnaround
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_req_holds:
        assert property (reqOut && !ackIn |=> reqOut) else $error("REQ dropped before ACK");
    a_req_after_ack:
        assert property ($rose(reqOut) |-> !$past(ackIn)) else $error("REQ rose with ACK high");
    a_lines_stable:
        assert property (reqOut |-> $stable({cdOut, ioOut, msgOut}))
        else $error("Phase lines moved during REQ");
    a_xfer_ack:
        assert property (xferAck == (reqOut && ackIn)) else $error("Byte ack not REQ and ACK");
    a_par_lo:
        assert property (dbParLoOut == ~^dbOut[7:0]) else $error("Low lane parity wrong");
    a_par_hi:
        assert property (dbParHiOut == ~^dbOut[15:8]) else $error("High lane parity wrong");
    a_oe_delay:
        assert property ($rose(dbOe) |-> $past(ioOut, 7)) else $error("Bus driven too early");
    a_oe_release:
        assert property ($fell(ioOut) |-> ##[0:1] !dbOe) else $error("Bus not released");
    a_msg_loop:
        assert property ({cdOut, ioOut, msgOut} == `SIPC_PH_MSG_OUT && atnIn && $fell(ackIn)
            |-> ##[1:12] reqOut) else $error("Message out stopped with ATN set");
    a_retry_code:
        assert property (msgRetryReq |-> {cdOut, ioOut, msgOut} == `SIPC_PH_MSG_OUT && !atnIn)
        else $error("Retry outside message out");
    a_abort_sense:
        assert property (abortReq |-> senseKey == 4'hB
            && (senseCode == 8'h47 || senseCode == 8'h43)) else $error("Abort sense wrong");

    // Main scenarios reached
    c_cmd_retry: cover property (cmdRetryReq);
    c_msg_retry: cover property (msgRetryReq);
    c_abort: cover property (abortReq);
    c_drive: cover property ($rose(dbOe));
endmodule // sipc_target_sva

bind sipc_target sipc_target_sva sipc_target_sva_i (.mclk(mclk), .resetn(resetn),
    .reqOut(reqOut), .ackIn(ackIn), .atnIn(atnIn), .cdOut(cdOut), .ioOut(ioOut),
    .msgOut(msgOut), .dbOe(dbOe), .xferAck(xferAck), .dbOut(dbOut), .dbParLoOut(dbParLoOut),
    .dbParHiOut(dbParHiOut), .msgRetryReq(msgRetryReq), .cmdRetryReq(cmdRetryReq),
    .abortReq(abortReq), .senseKey(senseKey), .senseCode(senseCode));
`default_nettype wire

// ===== sim/sipc_init_model.sv
/*
  Behavioural initiator: answers each REQ with ACK after a random delay.
  Assumes the bench supplies the outgoing word and a parity-corrupt flag.
*/
`timescale 1ns/1ps
`default_nettype none
module sipc_init_model
(
    input  wire logic        mclk,
    input  wire logic        reqOut,
    input  wire logic        ioOut,
    input  wire logic [15:0] dbOut,
    input  wire logic [15:0] sendWord,
    input  wire logic        badPar,
    output logic             ackIn,
    output logic [15:0]      dbIn,
    output logic             dbParLoIn,
    output logic             dbParHiIn,
    output logic [15:0]      rxWord,
    output int               hsCount
);
    // ==========================================
    // Handshake loop, acting after lines settle
    initial
    begin
        ackIn = 1'b0;
        dbIn = 16'h0000;
        dbParLoIn = 1'b1;
        dbParHiIn = 1'b1;
        rxWord = 16'h0000;
        hsCount = 0;
        forever
        begin
            @(posedge mclk);
            #2;
            if (reqOut === 1'b1)
            begin
                if (ioOut === 1'b0)
                begin
                    dbIn = sendWord;
                    dbParLoIn = (~^sendWord[7:0]) ^ badPar;
                    dbParHiIn = ~^sendWord[15:8];
                end
                for (int i = $urandom_range(2, 0); i > 0; i--)
                begin
                    @(posedge mclk);
                    #2;
                end
                if (ioOut === 1'b1)
                    rxWord = dbOut;
                ackIn = 1'b1;
                hsCount++;
                // Data held until the target lets REQ go
                while (reqOut !== 1'b0)
                begin
                    @(posedge mclk);
                    #2;
                end
                ackIn = 1'b0;
                dbIn = ~dbIn;
                dbParLoIn = ~dbParLoIn;
            end
        end
    end
endmodule // sipc_init_model
`default_nettype wire

// ===== sim/sipc_target_bench.sv
/*
  Self-checking bench for the target phase controller.
  Assumes the initiator model on the bus side; the bench drives ATN.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sipc_regs.svh"
module sipc_target_bench;
    import sipc_pkg::*;
    localparam logic [2:0] CODES [8] = '{`SIPC_PH_COMMAND, `SIPC_PH_DT_IN, `SIPC_PH_DT_OUT,
        `SIPC_PH_ST_IN, `SIPC_PH_ST_OUT, `SIPC_PH_STATUS, `SIPC_PH_MSG_IN, `SIPC_PH_MSG_OUT};
    logic        mclk, resetn, phaseReq, wideEn, txLast, xferReq, xferAck, badPar;
    sipc_phase_e phaseSel;
    logic [7:0]  txByte, rxByte, senseCode, lastRx;
    logic [3:0]  senseKey;
    logic        rxValid, rxAct, rxParErr, msgRetryReq, cmdRetryReq, abortReq, busFreeReq;
    logic        cdOut, ioOut, msgOut, reqOut, ackIn, atnIn, dbParLoIn, dbParHiIn;
    logic        dbParLoOut, dbParHiOut, dbOe;
    logic [15:0] dbIn, dbOut, sendWord, rxWord;
    int          hsCount, err_count, num_checks, cycles, nRetM, nRetC, nAbort, nAct, nPerr;

    sipc_target sipc_target_i (.mclk(mclk), .resetn(resetn), .phaseReq(phaseReq),
        .phaseSel(phaseSel), .wideEn(wideEn), .txByte(txByte), .txLast(txLast),
        .xferReq(xferReq), .xferAck(xferAck), .rxByte(rxByte), .rxValid(rxValid),
        .rxAct(rxAct), .rxParErr(rxParErr), .msgRetryReq(msgRetryReq),
        .cmdRetryReq(cmdRetryReq), .abortReq(abortReq), .senseKey(senseKey),
        .senseCode(senseCode), .busFreeReq(busFreeReq), .cdOut(cdOut), .ioOut(ioOut),
        .msgOut(msgOut), .reqOut(reqOut), .ackIn(ackIn), .atnIn(atnIn), .dbIn(dbIn),
        .dbParLoIn(dbParLoIn), .dbParHiIn(dbParHiIn), .dbOut(dbOut),
        .dbParLoOut(dbParLoOut), .dbParHiOut(dbParHiOut), .dbOe(dbOe));

    sipc_init_model sipc_init_model_i (.mclk(mclk), .reqOut(reqOut), .ioOut(ioOut),
        .dbOut(dbOut), .sendWord(sendWord), .badPar(badPar), .ackIn(ackIn), .dbIn(dbIn),
        .dbParLoIn(dbParLoIn), .dbParHiIn(dbParHiIn), .rxWord(rxWord), .hsCount(hsCount));

    // ==========================================
    // Clock, pulse monitors and hang limit
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (rxValid === 1'b1) lastRx <= rxByte;
        if (msgRetryReq === 1'b1) nRetM <= nRetM + 1;
        if (cmdRetryReq === 1'b1) nRetC <= nRetC + 1;
        if (abortReq === 1'b1) nAbort <= nAbort + 1;
        if (rxAct === 1'b1) nAct <= nAct + 1;
        if (rxParErr === 1'b1) nPerr <= nPerr + 1;
        if (cycles == 8000)
        begin
            err_count++;
            print_verdict();
        end
    end

    function automatic logic [2:0] phCode(input int p);
        return CODES[p];
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One phase of n handshakes, then expectations on the moved data
    task automatic runPhase(input int p, input int n, input logic bad, input logic atn,
        input logic wide);
        logic [7:0] b0, b1;
        int t;
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        nRetM = 0;
        nRetC = 0;
        nAbort = 0;
        nAct = 0;
        nPerr = 0;
        phaseSel = sipc_phase_e'(p);
        wideEn = wide;
        badPar = bad;
        sendWord = 16'($urandom);
        txByte = b0;
        txLast = !wide;
        atnIn = atn;
        xferReq = 1'b1;
        phaseReq = 1'b1;
        t = hsCount + n;
        @(posedge mclk);
        #2;
        // Low byte of a wide pair is staged by this one request cycle
        phaseReq = 1'b0;
        xferReq = 1'b0;
        chk("phase lines", 16'(phCode(p)), 16'({cdOut, ioOut, msgOut}));
        if (n != 2) atnIn = 1'b0;
        @(posedge mclk);
        #2;
        if (wide)
        begin
            txByte = b1;
            for (int k = 0; k < 300 && reqOut !== 1'b1; k++) @(posedge mclk);
            #2;
            txLast = 1'b1;
        end
        if (n == 2)
        begin
            for (int k = 0; k < 300 && !(hsCount == t - 1 && ackIn === 1'b0); k++)
                @(posedge mclk);
            #2;
            atnIn = 1'b0;
        end
        for (int k = 0; k < 300 && hsCount < t; k++) @(posedge mclk);
        repeat (12) @(posedge mclk);
        #2;
        xferReq = 1'b0;
        chk("handshakes", 16'(t), 16'(hsCount));
        if (phCode(p) & 3'h2) chk("low lane", 16'(b0), 16'(rxWord[7:0]));
        else if (!bad) chk("received byte", 16'(sendWord[7:0]), 16'(lastRx));
        if (wide) chk("high lane", 16'(b1), 16'(rxWord[15:8]));
        @(posedge mclk);
        #2;
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        void'($urandom(32'hB5073FB3));
        {resetn, phaseReq, wideEn, txLast, xferReq, badPar, atnIn} = 7'h01;
        {txByte, sendWord, lastRx} = 32'h0;
        phaseSel = SIPC_PHASE_COMMAND;
        {err_count, num_checks, cycles} = 96'h0;
        resetn = 1'b0;
        repeat (6) @(posedge mclk);
        #2;
        chk("reset outputs", 16'h0000, 16'({cdOut, ioOut, msgOut, reqOut, dbOe}));
        resetn = 1'b1;
        // Every phase code, random data, both directions
        for (int r = 0; r < 3; r++)
            for (int p = 0; p < 8; p++) runPhase(p, 1, 1'b0, 1'b0, 1'b0);
        // Initiator flags a status or message-in byte, then reports it in message out
        for (int p = 5; p < 7; p++)
        begin
            runPhase(p, 1, 1'b0, 1'b0, 1'b0);
            atnIn = 1'b1;
            runPhase(7, 1, 1'b0, 1'b1, 1'b0);
            chk("bytes acted", 16'h0001, 16'(nAct));
        end
        runPhase(3, 1, 1'b0, 1'b0, 1'b1);
        runPhase(7, 2, 1'b0, 1'b1, 1'b0);
        chk("message retries", 16'h0000, 16'(nRetM));
        chk("bytes acted", 16'h0002, 16'(nAct));
        chk("bus free", 16'h0000, 16'(busFreeReq));
        // Message out parity errors: two retries then abort
        runPhase(7, 3, 1'b1, 1'b1, 1'b0);
        chk("message retries", 16'h0002, 16'(nRetM));
        chk("aborts", 16'h0001, 16'(nAbort));
        chk("sense code", 16'h0043, 16'(senseCode));
        chk("bytes acted", 16'h0000, 16'(nAct));
        chk("parity errors", 16'h0003, 16'(nPerr));
        // Command parity errors: two retries then abort
        for (int k = 0; k < 3; k++)
        begin
            runPhase(0, 1, 1'b1, 1'b0, 1'b0);
            chk("command retry", 16'(k < 2), 16'(nRetC));
            chk("aborts", 16'(k == 2), 16'(nAbort));
            chk("parity errors", 16'h0001, 16'(nPerr));
        end
        chk("sense", 16'h0B47, {4'h0, senseKey, senseCode});
        print_verdict();
    end
endmodule // sipc_target_bench
`default_nettype wire
